// ==== design/usrt_ctrl.sv ====
// Serial port receiver/transmitter control, framing and a simple receiver.
// Assumes command and config words arrive as write strobes on clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "usrt_cfg.svh"
module usrt_ctrl (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	input wire logic thr_wr,
	input wire logic [8:0] thr_wdata,
	output logic thr_ready,
	input wire logic rx_read,
	input wire logic rxd,
	output logic txd,
	output logic [8:0] rx_data,
	output logic rx_ready,
	output logic rx_overrun,
	output logic rx_parity_err,
	output logic rx_frame_err,
	output logic rx_enabled,
	output logic tx_enabled,
	output logic tx_empty
);
	import usrt_pkg::*;

	usrt_ser_if ser_if ();

	logic [31:0] cfg_reg;
	logic [15:0] div_reg;
	logic half_tick;
	logic rx_en_reg, rx_dis_pend_reg, tx_en_reg, tx_dis_pend_reg;
	logic cmd_rx_en, cmd_rx_dis, cmd_tx_en, cmd_tx_dis, cmd_rst_rx, cmd_rst_tx;
	logic thr_full_reg;
	logic [8:0] thr_reg;
	logic [8:0] tg_cnt_reg;
	logic busy_q_reg;
	logic [3:0] nbits;
	usrt_par_e par_sel;
	logic [1:0] stop_sel;
	usrt_st_e rx_st_reg;
	logic [2:0] rx_hcnt_reg;
	logic [3:0] rx_idx_reg, rx_nb_reg;
	logic rx_hif_reg, rx_par_on_reg;
	logic [8:0] rx_sh_reg, rx_data_reg;
	logic rx_pbit_reg;
	logic rx_ready_reg, rx_ovr_reg, rx_perr_reg, rx_ferr_reg;
	logic rx_done;
	logic rx_last;
	logic [3:0] rx_idx_next;
	logic [8:0] rx_mask;

	// Command decode of one control write
	always_comb begin
		cmd_rx_en = ctrl_wr && ctrl_wdata[`USRT_CMD_RX_ON];
		cmd_rx_dis = ctrl_wr && ctrl_wdata[`USRT_CMD_RX_OFF];
		cmd_tx_en = ctrl_wr && ctrl_wdata[`USRT_CMD_TX_ON];
		cmd_tx_dis = ctrl_wr && ctrl_wdata[`USRT_CMD_TX_OFF];
		cmd_rst_rx = ctrl_wr && ctrl_wdata[`USRT_CMD_RX_SRST];
		cmd_rst_tx = ctrl_wr && ctrl_wdata[`USRT_CMD_TX_SRST];
	end

	// Config storage, independent of enable state and soft resets
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cfg_reg <= `USRT_CF_RESET;
		end else if (cfg_wr) begin
			cfg_reg <= cfg_wdata;
		end
	end

	// Framing decode of the config word
	always_comb begin
		nbits = cfg_reg[`USRT_CF_NINE] ? `USRT_NBITS_NINE
			: `USRT_NBITS_BASE + {2'b00, cfg_reg[`USRT_CF_CLEN_LSB +: 2]};
		par_sel = cfg_reg[`USRT_CF_PAR_LSB + 2] ? USRT_PAR_NONE
			: usrt_par_e'(cfg_reg[`USRT_CF_PAR_LSB +: 3]);
		stop_sel = cfg_reg[`USRT_CF_STOP_LSB +: 2];
	end

	// Half-bit rate divider, one-cycle enable pulse
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			div_reg <= 16'h0000;
		end else if (div_reg == 16'h0000) begin
			div_reg <= cfg_reg[`USRT_CF_DIV_LSB +: 16];
		end else begin
			div_reg <= div_reg - 16'h0001;
		end
	end
	assign half_tick = (div_reg == 16'h0000);

	// Receiver enable with deferred disable
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_en_reg <= 1'b0;
			rx_dis_pend_reg <= 1'b0;
		end else if (cmd_rx_dis) begin
			rx_dis_pend_reg <= (rx_st_reg != USRT_ST_IDLE) && !cmd_rst_rx;
			rx_en_reg <= rx_en_reg && (rx_st_reg != USRT_ST_IDLE) && !cmd_rst_rx;
		end else if (cmd_rx_en) begin
			rx_en_reg <= 1'b1;
			rx_dis_pend_reg <= 1'b0;
		end else if (rx_dis_pend_reg && (rx_st_reg == USRT_ST_IDLE || cmd_rst_rx)) begin
			rx_en_reg <= 1'b0;
			rx_dis_pend_reg <= 1'b0;
		end
	end

	// Transmitter enable with drain on disable
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_en_reg <= 1'b0;
			tx_dis_pend_reg <= 1'b0;
		end else if (cmd_tx_dis) begin
			tx_dis_pend_reg <= tx_en_reg;
		end else if (cmd_tx_en) begin
			tx_en_reg <= 1'b1;
			tx_dis_pend_reg <= 1'b0;
		end else if (tx_dis_pend_reg && !thr_full_reg && !ser_if.busy && tg_cnt_reg == 9'h000
			&& !busy_q_reg) begin
			tx_en_reg <= 1'b0;
			tx_dis_pend_reg <= 1'b0;
		end
	end

	// Transmit holding register
	assign thr_ready = tx_en_reg && !tx_dis_pend_reg && !thr_full_reg;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			thr_full_reg <= 1'b0;
			thr_reg <= 9'h000;
		end else if (cmd_rst_tx) begin
			thr_full_reg <= 1'b0;
		end else if (thr_wr && thr_ready) begin
			thr_full_reg <= 1'b1;
			thr_reg <= thr_wdata;
		end else if (ser_if.load && !ser_if.busy) begin
			thr_full_reg <= 1'b0;
		end
	end

	// Timeguard gap after each character, counted in half bits
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			busy_q_reg <= 1'b0;
			tg_cnt_reg <= 9'h000;
		end else if (cmd_rst_tx) begin
			busy_q_reg <= 1'b0;
			tg_cnt_reg <= 9'h000;
		end else begin
			busy_q_reg <= ser_if.busy;
			if (busy_q_reg && !ser_if.busy) begin
				tg_cnt_reg <= {2'b00, cfg_reg[`USRT_CF_TG_LSB +: 6], 1'b0};
			end else if (half_tick && tg_cnt_reg != 9'h000) begin
				tg_cnt_reg <= tg_cnt_reg - 9'h001;
			end
		end
	end

	// Serializer hookup; launch only on a half tick so the start bit is a whole bit
	always_comb begin
		ser_if.half_tick = half_tick;
		ser_if.abort = cmd_rst_tx;
		ser_if.load = tx_en_reg && thr_full_reg && tg_cnt_reg <= 9'h001 && !busy_q_reg && half_tick;
		ser_if.data = thr_reg;
		ser_if.nbits = nbits;
		ser_if.par = par_sel;
		ser_if.msb_first = cfg_reg[`USRT_CF_HIFIRST];
		unique case (stop_sel)
			2'h0: ser_if.stop_halves = `USRT_HALVES_BIT;
			2'h1: ser_if.stop_halves = cfg_reg[`USRT_CF_SYNC] ? `USRT_HALVES_BIT
				: `USRT_HALVES_1P5;
			default: ser_if.stop_halves = `USRT_HALVES_2;
		endcase
	end

	usrt_tx_ser u_tx_ser (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.s(ser_if.ser)
	);

	// Receive bit walk and parity mask
	always_comb begin
		rx_last = rx_hif_reg ? (rx_idx_reg == 4'h0) : (rx_idx_reg == rx_nb_reg - 4'h1);
		rx_idx_next = rx_hif_reg ? rx_idx_reg - 4'h1 : rx_idx_reg + 4'h1;
		rx_mask = 9'h1FF >> (4'h9 - rx_nb_reg);
	end
	assign rx_done = half_tick && rx_st_reg == USRT_ST_STOP && rx_hcnt_reg == 3'h1
		&& !cmd_rst_rx;

	// Receiver sequencer, samples at mid bit
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_st_reg <= USRT_ST_IDLE;
			rx_hcnt_reg <= 3'h0;
			rx_idx_reg <= 4'h0;
			rx_nb_reg <= `USRT_NBITS_BASE;
			rx_hif_reg <= 1'b0;
			rx_par_on_reg <= 1'b0;
			rx_sh_reg <= 9'h000;
			rx_pbit_reg <= 1'b0;
		end else if (cmd_rst_rx) begin
			rx_st_reg <= USRT_ST_IDLE;
		end else if (half_tick) begin
			if (rx_st_reg == USRT_ST_IDLE) begin
				if (rx_en_reg && !rx_dis_pend_reg && !rxd) begin
					rx_st_reg <= USRT_ST_START;
					rx_hcnt_reg <= 3'h1;
					rx_nb_reg <= nbits;
					rx_hif_reg <= cfg_reg[`USRT_CF_HIFIRST];
					rx_par_on_reg <= (par_sel != USRT_PAR_NONE);
					rx_idx_reg <= cfg_reg[`USRT_CF_HIFIRST] ? nbits - 4'h1 : 4'h0;
					rx_sh_reg <= 9'h000;
				end
			end else if (rx_hcnt_reg != 3'h1) begin
				rx_hcnt_reg <= rx_hcnt_reg - 3'h1;
			end else begin
				rx_hcnt_reg <= `USRT_HALVES_BIT;
				unique case (rx_st_reg)
					USRT_ST_START: rx_st_reg <= rxd ? USRT_ST_IDLE : USRT_ST_DATA;
					USRT_ST_DATA: begin
						rx_sh_reg[rx_idx_reg] <= rxd;
						rx_idx_reg <= rx_idx_next;
						if (rx_last) begin
							rx_st_reg <= rx_par_on_reg ? USRT_ST_PAR : USRT_ST_STOP;
						end
					end
					USRT_ST_PAR: begin
						rx_pbit_reg <= rxd;
						rx_st_reg <= USRT_ST_STOP;
					end
					default: rx_st_reg <= USRT_ST_IDLE;
				endcase
			end
		end
	end

	// Receive data and sticky flags; a new character beats a same-cycle read
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_data_reg <= 9'h000;
			rx_ready_reg <= 1'b0;
			rx_ovr_reg <= 1'b0;
			rx_perr_reg <= 1'b0;
			rx_ferr_reg <= 1'b0;
		end else if (cmd_rst_rx) begin
			rx_ready_reg <= 1'b0;
			rx_ovr_reg <= 1'b0;
			rx_perr_reg <= 1'b0;
			rx_ferr_reg <= 1'b0;
		end else if (rx_done) begin
			rx_data_reg <= rx_sh_reg;
			rx_ready_reg <= 1'b1;
			rx_ovr_reg <= rx_ovr_reg || (rx_ready_reg && !rx_read);
			rx_ferr_reg <= rx_ferr_reg || !rxd;
			unique case (par_sel)
				USRT_PAR_EVEN: rx_perr_reg <= rx_perr_reg || (^(rx_sh_reg & rx_mask) != rx_pbit_reg);
				USRT_PAR_ODD: rx_perr_reg <= rx_perr_reg || (~^(rx_sh_reg & rx_mask) != rx_pbit_reg);
				USRT_PAR_SPACE: rx_perr_reg <= rx_perr_reg || rx_pbit_reg;
				USRT_PAR_MARK: rx_perr_reg <= rx_perr_reg || !rx_pbit_reg;
				default: rx_perr_reg <= rx_perr_reg;
			endcase
		end else if (rx_read) begin
			rx_ready_reg <= 1'b0;
			rx_ovr_reg <= 1'b0;
			rx_perr_reg <= 1'b0;
			rx_ferr_reg <= 1'b0;
		end
	end

	// Outputs
	assign cfg_rdata = cfg_reg;
	assign txd = ser_if.txd;
	assign rx_data = rx_data_reg;
	assign rx_ready = rx_ready_reg;
	assign rx_overrun = rx_ovr_reg;
	assign rx_parity_err = rx_perr_reg;
	assign rx_frame_err = rx_ferr_reg;
	assign rx_enabled = rx_en_reg;
	assign tx_enabled = tx_en_reg;
	assign tx_empty = !thr_full_reg && !ser_if.busy && tg_cnt_reg == 9'h000;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	AST_RX_EN_CAUSE: assert property ($rose(rx_en_reg) |-> $past(cmd_rx_en && !cmd_rx_dis))
		else $error("receiver enabled without enable command");
	AST_TX_EN_CAUSE: assert property ($rose(tx_en_reg) |-> $past(cmd_tx_en && !cmd_tx_dis))
		else $error("transmitter enabled without enable command");
	AST_CFG_KEPT: assert property (cfg_wr |=> cfg_reg == $past(cfg_wdata))
		else $error("config write not retained");
	AST_BOTH_EN: assert property (ctrl_wr && ctrl_wdata[5:0] == 6'h05 |=> rx_en_reg && tx_en_reg)
		else $error("joint enable failed");
	AST_RX_SRST: assert property (cmd_rst_rx |=> !rx_ready_reg && rx_st_reg == USRT_ST_IDLE)
		else $error("receiver soft reset incomplete");
	AST_TX_ABORT: assert property (cmd_rst_tx |=> !ser_if.busy && txd && !thr_full_reg)
		else $error("transmit not aborted");
	AST_RX_DRAIN: assert property (rx_en_reg && rx_st_reg != USRT_ST_IDLE && !cmd_rst_rx |=> rx_en_reg)
		else $error("receiver stopped mid character");
	AST_TX_DRAIN: assert property (tx_en_reg && (thr_full_reg || ser_if.busy) |=> tx_en_reg)
		else $error("transmitter stopped with data pending");
	AST_TG_DRAIN: assert property (tx_en_reg && tg_cnt_reg != 9'h000 |=> tx_en_reg)
		else $error("timeguard cut short");
	AST_START_LOW: assert property (ser_if.load && !ser_if.busy && !cmd_rst_tx |=> !txd)
		else $error("start bit missing");
	AST_NINE: assert property (cfg_reg[`USRT_CF_NINE] |-> nbits == `USRT_NBITS_NINE)
		else $error("nine-bit select ignored");
	AST_SYNC_STOP: assert property (cfg_reg[`USRT_CF_SYNC] |-> ser_if.stop_halves != `USRT_HALVES_1P5)
		else $error("1.5 stop bits in clocked mode");
	AST_DIS_WINS: assert property (cmd_rx_en && cmd_rx_dis && !rx_en_reg |=> !rx_en_reg)
		else $error("enable beat disable");

	COV_TX_CHAR: cover property (ser_if.busy ##1 !ser_if.busy);
	COV_RX_CHAR: cover property (rx_done);
	COV_TX_DRAIN: cover property (tx_dis_pend_reg ##1 !tx_en_reg);
endmodule : usrt_ctrl
`default_nettype wire

// ==== design/usrt_cfg.svh ====
// Constants of the serial port control block: command bits, config fields.
// Assumes a single includer set; guarded against double inclusion.
`ifndef USRT_CFG_SVH
`define USRT_CFG_SVH

// Control word command bits
`define USRT_CMD_RX_ON 0
`define USRT_CMD_RX_OFF 1
`define USRT_CMD_TX_ON 2
`define USRT_CMD_TX_OFF 3
`define USRT_CMD_RX_SRST 4
`define USRT_CMD_TX_SRST 5

// Config word field positions; timeguard is six bits, clear of the divider
`define USRT_CF_CLEN_LSB 0
`define USRT_CF_NINE 2
`define USRT_CF_PAR_LSB 3
`define USRT_CF_HIFIRST 6
`define USRT_CF_STOP_LSB 7
`define USRT_CF_SYNC 9
`define USRT_CF_TG_LSB 10
`define USRT_CF_DIV_LSB 16

// Reset value of the config word
`define USRT_CF_RESET 32'h0000_0000

// Half-bit counts: one bit, 1.5 stop bits, two stop bits
`define USRT_HALVES_BIT 3'h2
`define USRT_HALVES_1P5 3'h3
`define USRT_HALVES_2 3'h4

// Data-bit count base and nine-bit count
`define USRT_NBITS_BASE 4'h5
`define USRT_NBITS_NINE 4'h9

`endif

// ==== design/usrt_pkg.sv ====
// Types shared by the serial port control block and its serializer.
// Assumes usrt_cfg.svh for numeric constants.
`default_nettype none
package usrt_pkg;
	typedef enum logic [2:0] {
		USRT_PAR_EVEN = 3'h0,
		USRT_PAR_ODD = 3'h1,
		USRT_PAR_SPACE = 3'h2,
		USRT_PAR_MARK = 3'h3,
		USRT_PAR_NONE = 3'h4
	} usrt_par_e;

	typedef enum logic [4:0] {
		USRT_ST_IDLE = 5'h01,
		USRT_ST_START = 5'h02,
		USRT_ST_DATA = 5'h04,
		USRT_ST_PAR = 5'h08,
		USRT_ST_STOP = 5'h10
	} usrt_st_e;
endpackage : usrt_pkg
`default_nettype wire

// ==== design/usrt_ser_if.sv ====
// Link between the control block and the transmit serializer.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface usrt_ser_if;
	logic half_tick;
	logic load;
	logic abort;
	logic [8:0] data;
	logic [3:0] nbits;
	usrt_pkg::usrt_par_e par;
	logic msb_first;
	logic [2:0] stop_halves;
	logic busy;
	logic txd;
	modport ctl (output half_tick, load, abort, data, nbits, par, msb_first, stop_halves,
		input busy, txd);
	modport ser (input half_tick, load, abort, data, nbits, par, msb_first, stop_halves,
		output busy, txd);
endinterface : usrt_ser_if
`default_nettype wire

// ==== design/usrt_tx_ser.sv ====
// Transmit serializer: start, data, optional parity and stop bits.
// Assumes half_tick is a one-cycle pulse every half serial bit period.
`timescale 1ns/1ns
`default_nettype none
`include "usrt_cfg.svh"
module usrt_tx_ser (
	input wire logic clk_sys,
	input wire logic resetn,
	usrt_ser_if.ser s
);
	import usrt_pkg::*;

	usrt_st_e st_reg;
	logic [2:0] hcnt_reg;
	logic [3:0] idx_reg;
	logic [3:0] nb_reg;
	logic [8:0] data_reg;
	logic hif_reg;
	logic par_on_reg;
	logic par_bit_reg;
	logic [2:0] stop_reg;
	logic txd_reg;
	logic last_bit;
	logic [3:0] idx_next;

	// Parity bit over the used data bits
	function automatic logic calc_par(input logic [8:0] d, input logic [3:0] n,
		input usrt_par_e p);
		logic [8:0] m;
		m = d & (9'h1FF >> (4'h9 - n));
		unique case (p)
			USRT_PAR_EVEN: calc_par = ^m;
			USRT_PAR_ODD: calc_par = ~^m;
			USRT_PAR_MARK: calc_par = 1'b1;
			default: calc_par = 1'b0;
		endcase
	endfunction : calc_par

	// Bit order walk
	always_comb begin
		last_bit = hif_reg ? (idx_reg == 4'h0) : (idx_reg == nb_reg - 4'h1);
		idx_next = hif_reg ? idx_reg - 4'h1 : idx_reg + 4'h1;
	end

	// Character sequencer; every change except an abort lands on a half-tick boundary
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= USRT_ST_IDLE;
			hcnt_reg <= 3'h0;
			idx_reg <= 4'h0;
			nb_reg <= `USRT_NBITS_BASE;
			data_reg <= 9'h000;
			hif_reg <= 1'b0;
			par_on_reg <= 1'b0;
			par_bit_reg <= 1'b0;
			stop_reg <= `USRT_HALVES_BIT;
			txd_reg <= 1'b1;
		end else if (s.abort) begin
			st_reg <= USRT_ST_IDLE;
			txd_reg <= 1'b1;
		end else if (s.load && st_reg == USRT_ST_IDLE) begin
			data_reg <= s.data;
			nb_reg <= s.nbits;
			hif_reg <= s.msb_first;
			par_on_reg <= (s.par != USRT_PAR_NONE) && !s.par[2];
			par_bit_reg <= calc_par(s.data, s.nbits, s.par);
			stop_reg <= s.stop_halves;
			idx_reg <= s.msb_first ? s.nbits - 4'h1 : 4'h0;
			st_reg <= USRT_ST_START;
			txd_reg <= 1'b0;
			hcnt_reg <= `USRT_HALVES_BIT;
		end else if (s.half_tick && st_reg != USRT_ST_IDLE) begin
			if (hcnt_reg != 3'h1) begin
				hcnt_reg <= hcnt_reg - 3'h1;
			end else begin
				hcnt_reg <= `USRT_HALVES_BIT;
				unique case (st_reg)
					USRT_ST_START: begin
						st_reg <= USRT_ST_DATA;
						txd_reg <= data_reg[idx_reg];
					end
					USRT_ST_DATA: begin
						if (!last_bit) begin
							idx_reg <= idx_next;
							txd_reg <= data_reg[idx_next];
						end else if (par_on_reg) begin
							st_reg <= USRT_ST_PAR;
							txd_reg <= par_bit_reg;
						end else begin
							st_reg <= USRT_ST_STOP;
							txd_reg <= 1'b1;
							hcnt_reg <= stop_reg;
						end
					end
					USRT_ST_PAR: begin
						st_reg <= USRT_ST_STOP;
						txd_reg <= 1'b1;
						hcnt_reg <= stop_reg;
					end
					USRT_ST_STOP: begin
						st_reg <= USRT_ST_IDLE;
					end
					default: begin
						st_reg <= USRT_ST_IDLE;
						txd_reg <= 1'b1;
					end
				endcase
			end
		end
	end

	assign s.busy = (st_reg != USRT_ST_IDLE);
	assign s.txd = txd_reg;
endmodule : usrt_tx_ser
`default_nettype wire

// ==== verification/usrt_remote.sv ====
// Remote serial device model: sends frames on rxd and decodes frames on txd.
// Assumes clk_sys as the time base; the caller sets the bit time as 2*h cycles.
`timescale 1ns/1ns
`default_nettype none
module usrt_remote (
	input wire logic clk_sys,
	input wire logic txd,
	output var logic rxd
);
	int cyc = 0;
	int fall_cyc = 0;
	initial rxd = 1'b1;

	// Free-running cycle count for frame timing
	always @(posedge clk_sys) cyc <= cyc + 1;

	// Check bit over the first n data bits
	function automatic logic pbit(logic [8:0] d, int n, int p);
		logic x;
		x = 1'b0;
		for (int i = 0; i < n; i++) x ^= d[i];
		case (p)
			0: return x;
			1: return ~x;
			2: return 1'b0;
			default: return 1'b1;
		endcase
	endfunction : pbit

	// One frame on rxd, idle high after the stop bit; bad flips the check bit
	task automatic send(logic [8:0] d, int n, int p, bit m, int h, bit bad);
		logic [11:0] f;
		int k;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < n; i++) f[1 + i] = m ? d[n - 1 - i] : d[i];
		k = n + 1;
		if (p < 4) begin
			f[k] = pbit(d, n, p) ^ bad;
			k++;
		end
		for (int i = 0; i <= k; i++) begin
			@(posedge clk_sys);
			rxd <= f[i];
			repeat (2 * h - 1) @(posedge clk_sys);
		end
	endtask : send

	// Decode one frame from txd at mid-bit; ok says start low and stop high
	task automatic grab(int n, bit pe, bit m, int h, output logic [8:0] d,
		output logic pb, output logic ok);
		int w;
		d = '0;
		pb = 1'b0;
		w = 0;
		while (txd !== 1'b0 && w < 4000) begin
			@(negedge clk_sys);
			w++;
		end
		fall_cyc = cyc;
		repeat (h) @(negedge clk_sys);
		ok = (txd === 1'b0);
		for (int i = 0; i < n; i++) begin
			repeat (2 * h) @(negedge clk_sys);
			if (m)
				d[n - 1 - i] = txd;
			else
				d[i] = txd;
		end
		if (pe) begin
			repeat (2 * h) @(negedge clk_sys);
			pb = txd;
		end
		repeat (2 * h) @(negedge clk_sys);
		ok = ok & (txd === 1'b1);
	endtask : grab
endmodule : usrt_remote
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench of the serial port control block.
// Assumes usrt_remote as far side, clk_sys at 125 MHz, half-bit divider 4.
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int H = 5;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic ctrl_wr = 1'b0;
	logic cfg_wr = 1'b0;
	logic thr_wr = 1'b0;
	logic rx_read = 1'b0;
	logic [7:0] ctrl_wdata = '0;
	logic [31:0] cfg_wdata = '0;
	logic [8:0] thr_wdata = '0;
	logic [31:0] cfg_rdata;
	logic [8:0] rx_data;
	logic rxd, txd, thr_ready, rx_ready, rx_overrun, rx_parity_err, rx_frame_err;
	logic rx_enabled, tx_enabled, tx_empty;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;

	usrt_ctrl uut (.clk_sys(clk_sys), .resetn(resetn), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .thr_wr(thr_wr), .thr_wdata(thr_wdata),
		.thr_ready(thr_ready), .rx_read(rx_read), .rxd(rxd), .txd(txd),
		.rx_data(rx_data), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
		.rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err),
		.rx_enabled(rx_enabled), .tx_enabled(tx_enabled), .tx_empty(tx_empty));
	usrt_remote rem (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

	// Clock and hang guard
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One strobe: 0 control, 1 config, 2 holding, 3 receive read
	task automatic wr(int s, logic [31:0] w);
		@(posedge clk_sys);
		ctrl_wr <= (s == 0);
		cfg_wr <= (s == 1);
		thr_wr <= (s == 2);
		rx_read <= (s == 3);
		ctrl_wdata <= w[7:0];
		cfg_wdata <= w;
		thr_wdata <= w[8:0];
		@(posedge clk_sys);
		{ctrl_wr, cfg_wr, thr_wr, rx_read} <= 4'h0;
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask : wr

	task automatic wait_for(ref logic s, input logic v);
		int w;
		w = 0;
		while (s !== v && w < 2000) begin
			@(negedge clk_sys);
			w++;
		end
	endtask : wait_for

	// Config word with half-bit divider 4
	function automatic logic [31:0] cw(int cl, int nn, int p, int m, int st, int sy, int tg);
		return 32'h0004_0000 | (tg << 10) | (sy << 9) | (st << 7) | (m << 6) | (p << 3)
			| (nn << 2) | cl;
	endfunction : cw

	// Send one character each way with the given framing
	task automatic frame(logic [8:0] d, int cl, int nn, int p, int m, int st, int sy, bit bad);
		int n, len, e, hv;
		logic [8:0] g;
		logic pb, ok;
		n = nn ? 9 : cl + 5;
		wr(1, cw(cl, nn, p, m, st, sy, 0));
		fork
			rem.grab(n, p < 4, m, H, g, pb, ok);
			wr(2, d);
		join
		wait_for(tx_empty, 1'b1);
		len = rem.cyc - rem.fall_cyc;
		chk(g, d & ((1 << n) - 1));
		chk(ok, 1'b1);
		if (p < 4)
			chk(pb, rem.pbit(d, n, p));
		e = (2 * n + 2 + 2 * (p < 4)) * H;
		hv = (st == 0 || (st == 1 && sy == 1)) ? 2 : (st == 1) ? 3 : 4;
		chk(len >= e + hv * H - 2 && len <= e + hv * H + 2, 1'b1);
		rem.send(d, n, p, m, H, bad);
		wait_for(rx_ready, 1'b1);
		chk(rx_data, d & ((1 << n) - 1));
		chk({rx_frame_err, rx_overrun}, 2'b00);
		chk(rx_parity_err, bad && p < 4);
		wr(3, 0);
		chk(rx_ready, 1'b0);
	endtask : frame

	// Main sequence
	initial begin
		logic [8:0] g;
		logic pb, ok;
		int t0;
		void'($urandom(32'hc17b));
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(negedge clk_sys);
		chk({rx_enabled, tx_enabled, txd, thr_ready, tx_empty}, 5'b00101);
		wr(1, cw(3, 0, 1, 1, 2, 0, 0));
		chk(cfg_rdata, cw(3, 0, 1, 1, 2, 0, 0));
		wr(2, 9'h0A5);
		chk({txd, tx_empty}, 2'b11);
		rem.send(9'h05A, 8, 1, 1, H, 0);
		repeat (20) @(negedge clk_sys);
		chk(rx_ready, 1'b0);
		wr(0, 8'h03);
		chk(rx_enabled, 1'b0);
		wr(0, 8'h0C);
		chk(tx_enabled, 1'b0);
		wr(0, 8'h01);
		chk({rx_enabled, tx_enabled}, 2'b10);
		wr(0, 8'h02);
		wr(0, 8'h05);
		chk({rx_enabled, tx_enabled}, 2'b11);
		for (int i = 0; i < 15; i++)
			frame($urandom, $urandom_range(3, 0), i % 4 == 3, i % 5, $urandom_range(1, 0),
				i % 3, $urandom_range(1, 0), i % 3 == 2);
		// Disable while one character is sent and one is held, timeguard of 2 bits
		wr(1, cw(3, 0, 4, 0, 0, 0, 2));
		fork
			rem.grab(8, 0, 0, H, g, pb, ok);
			begin
				wr(2, 9'h0C3);
				wait_for(thr_ready, 1'b1);
				wr(2, 9'h03C);
				wr(0, 8'h08);
			end
		join
		t0 = rem.fall_cyc;
		chk(g, 9'h0C3);
		chk(tx_enabled, 1'b1);
		rem.grab(8, 0, 0, H, g, pb, ok);
		chk(g, 9'h03C);
		chk(rem.fall_cyc - t0 >= 118 && rem.fall_cyc - t0 <= 122, 1'b1);
		wait_for(tx_enabled, 1'b0);
		chk({tx_enabled, txd}, 2'b01);
		// Receiver disable in mid-character
		fork
			rem.send(9'h05A, 8, 4, 0, H, 0);
			begin
				repeat (30) @(posedge clk_sys);
				wr(0, 8'h02);
				chk(rx_enabled, 1'b1);
			end
		join
		wait_for(rx_ready, 1'b1);
		chk(rx_data, 9'h05A);
		wait_for(rx_enabled, 1'b0);
		chk(rx_enabled, 1'b0);
		wr(3, 0);
		// Transmit soft reset in mid-character
		wr(0, 8'h04);
		wr(2, 9'h000);
		repeat (30) @(negedge clk_sys);
		chk(txd, 1'b0);
		wr(0, 8'h20);
		chk({txd, tx_empty}, 2'b11);
		chk(cfg_rdata, cw(3, 0, 4, 0, 0, 0, 2));
		repeat (60) @(negedge clk_sys);
		chk(txd, 1'b1);
		// Bad check bit under even parity sets a parity error
		wr(0, 8'h01);
		wr(1, cw(3, 0, 0, 0, 0, 0, 0));
		rem.send(9'h033, 8, 0, 0, H, 1);
		wait_for(rx_ready, 1'b1);
		chk(rx_parity_err, 1'b1);
		// Second character before any read: overrun, error flags stay sticky
		rem.send(9'h0F0, 8, 0, 0, H, 0);
		repeat (2 * H) @(negedge clk_sys);
		chk({rx_overrun, rx_parity_err, rx_data}, {2'b11, 9'h0F0});
		wr(0, 8'h10);
		chk({rx_ready, rx_parity_err, rx_overrun, rx_enabled}, 4'b0001);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
